// ==== include/logic_ops_pkg.sv ====
// package: operation codes, widths, reset values and timing of the logical datapath
// How it works
// - and a direct byte into the accumulator, two bytes, one cycle
// - and the pointer-addressed ram byte into the accumulator, one byte, one cycle
// - and the immediate byte into the accumulator, two bytes, one cycle
// - and the accumulator into a direct byte, written back, accumulator kept
// - and immediate into a direct byte, three bytes, two cycles
// - or a bank register into the accumulator, one byte, one cycle
// - or the pointer-addressed ram byte into the accumulator, one cycle
// - or the accumulator into a direct byte, written back there
// - or immediate into a direct byte, three bytes, two cycles
// - xor a bank register into the accumulator, one byte, one cycle
// - xor a direct byte into the accumulator, two bytes, one cycle
// - xor the pointer-addressed ram byte into the accumulator, one byte
// - xor the immediate byte into the accumulator, two bytes
// - clear the accumulator to zero in one cycle
// - invert every accumulator bit in one cycle
// - rotate accumulator left, bit 7 wraps to bit 0
// - rotate left through carry: bit 7 to carry, carry to bit 0
// - rotate accumulator right, bit 0 wraps to bit 7
// - rotate right through carry: bit 0 to carry, carry to bit 7
// - swap the accumulator nibbles in one cycle
// - copy a bank register into the accumulator in one cycle
package logic_ops_pkg;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ------------------------------------------------------------
  // machine cycles and instruction lengths
  // ------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ------------------------------------------------------------
  // operand sources and operation kinds
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_BANK = 2'h0,
    SRC_DIRECT = 2'h1,
    SRC_INDIRECT = 2'h2,
    SRC_IMMEDIATE = 2'h3
  } src_t;

  typedef enum logic [3:0] {
    OP_AND = 4'h0,
    OP_OR = 4'h1,
    OP_XOR = 4'h2,
    OP_CLEAR = 4'h3,
    OP_COMPL = 4'h4,
    OP_ROT_L = 4'h5,
    OP_ROT_LC = 4'h6,
    OP_ROT_R = 4'h7,
    OP_ROT_RC = 4'h8,
    OP_SWAP = 4'h9,
    OP_MOVE = 4'hA
  } op_t;

  // request from the fetch/decode sequencer
  typedef struct packed {
    op_t op;
    src_t src;
    logic to_direct;
    logic [7:0] operand;
    logic [7:0] immediate;
  } logic_req_t;

  // write-back of a direct byte
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } direct_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SECOND = 2'b10
  } seq_state_t;

endpackage : logic_ops_pkg

// ==== core/logic_unit.sv ====
// combinational byte unit for the logical and rotate operations
`timescale 1ns/1ps
`default_nettype none
module logic_unit (
  input wire logic_ops_pkg::op_t op,
  input wire logic [7:0] acc,
  input wire logic carry,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  output logic [7:0] result,
  output logic carry_out
);
  import logic_ops_pkg::*;

  always_comb begin
    result = a_in;
    carry_out = carry;
    case (op)
      OP_AND: result = a_in & b_in;
      OP_OR: result = a_in | b_in;
      OP_XOR: result = a_in ^ b_in;
      OP_CLEAR: result = 8'h00;
      OP_COMPL: result = ~acc;
      OP_ROT_L: result = {acc[6:0], acc[7]};
      OP_ROT_LC: begin
        result = {acc[6:0], carry};
        carry_out = acc[7];
      end
      OP_ROT_R: result = {acc[0], acc[7:1]};
      OP_ROT_RC: begin
        result = {carry, acc[7:1]};
        carry_out = acc[0];
      end
      OP_SWAP: result = {acc[3:0], acc[7:4]};
      OP_MOVE: result = b_in;
      default: result = a_in;
    endcase
  end

endmodule : logic_unit
`default_nettype wire

// ==== core/accumulator_logic_ops.sv ====
// accumulator-centred logical datapath with direct-byte write-back
`timescale 1ns/1ps
`default_nettype none
module accumulator_logic_ops (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic_ops_pkg::logic_req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] acc,
  output logic carry,
  output logic parity,
  output logic_ops_pkg::direct_wr_t direct_wr,
  output logic [1:0] instr_len
);
  import logic_ops_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  seq_state_t state_reg, state_next;
  logic [7:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic done_reg, done_next;
  direct_wr_t wr_reg, wr_next;
  logic [1:0] len_reg, len_next;
  logic [7:0] hold_a_reg, hold_a_next;
  logic [7:0] hold_b_reg, hold_b_next;
  op_t hold_op_reg, hold_op_next;

  logic [7:0] unit_a, unit_b, unit_res;
  logic unit_carry;
  op_t unit_op;
  logic accept;
  logic two_cycle;

  assign req_ready = (state_reg == ST_IDLE);
  assign accept = req_valid && req_ready;
  // immediate into a direct byte needs a second machine cycle
  assign two_cycle = req.to_direct && (req.src == SRC_IMMEDIATE);

  // ------------------------------------------------------------
  // operand steering
  // ------------------------------------------------------------
  always_comb begin
    unit_op = req.op;
    unit_a = acc_reg;
    unit_b = (req.src == SRC_IMMEDIATE) ? req.immediate : req.operand;
    if (state_reg == ST_SECOND) begin
      unit_op = hold_op_reg;
      unit_a = hold_a_reg;
      unit_b = hold_b_reg;
    end else if (req.to_direct) begin
      // direct target: direct byte is one side, acc or immediate the other
      unit_a = req.operand;
      unit_b = (req.src == SRC_IMMEDIATE) ? req.immediate : acc_reg;
    end
  end

  logic_unit u_unit (
    .op(unit_op),
    .acc(acc_reg),
    .carry(carry_reg),
    .a_in(unit_a),
    .b_in(unit_b),
    .result(unit_res),
    .carry_out(unit_carry)
  );

  // ------------------------------------------------------------
  // sequencing and result registers
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    acc_next = acc_reg;
    carry_next = carry_reg;
    done_next = 1'b0;
    wr_next = '{valid: 1'b0, data: wr_reg.data};
    len_next = len_reg;
    hold_a_next = hold_a_reg;
    hold_b_next = hold_b_reg;
    hold_op_next = hold_op_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          if (two_cycle) begin
            // operands held; write-back lands on the second cycle
            hold_a_next = req.operand;
            hold_b_next = req.immediate;
            hold_op_next = req.op;
            len_next = LEN_THREE;
            state_next = ST_SECOND;
          end else if (req.to_direct) begin
            wr_next = '{valid: 1'b1, data: unit_res};
            len_next = LEN_TWO;
            done_next = 1'b1;
          end else begin
            acc_next = unit_res;
            carry_next = unit_carry;
            done_next = 1'b1;
            case (req.src)
              SRC_DIRECT: len_next = LEN_TWO;
              SRC_IMMEDIATE: len_next = LEN_TWO;
              default: len_next = LEN_ONE;
            endcase
            if (req.op inside {OP_CLEAR, OP_COMPL, OP_ROT_L, OP_ROT_LC,
                               OP_ROT_R, OP_ROT_RC, OP_SWAP, OP_MOVE}) begin
              len_next = LEN_ONE;
            end
          end
        end
      end
      ST_SECOND: begin
        wr_next = '{valid: 1'b1, data: unit_res};
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      acc_reg <= ACC_RESET;
      carry_reg <= CARRY_RESET;
      done_reg <= 1'b0;
      wr_reg <= '{valid: 1'b0, data: RESULT_RESET};
      len_reg <= LEN_ONE;
      hold_a_reg <= RESULT_RESET;
      hold_b_reg <= RESULT_RESET;
      hold_op_reg <= OP_AND;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      done_reg <= done_next;
      wr_reg <= wr_next;
      len_reg <= len_next;
      hold_a_reg <= hold_a_next;
      hold_b_reg <= hold_b_next;
      hold_op_reg <= hold_op_next;
    end
  end

  assign acc = acc_reg;
  assign carry = carry_reg;
  // parity is derived, so it cannot lag the accumulator
  assign parity = ^acc_reg;
  assign done = done_reg;
  assign direct_wr = wr_reg;
  assign instr_len = len_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_and_acc;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_AND && !req.to_direct && req.src == SRC_DIRECT
      |=> acc == ($past(acc) & $past(req.operand)) && done;
  endproperty
  a_and_acc: assert property (p_and_acc) else $error("and direct wrong");

  property p_and_imm;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_AND && !req.to_direct && req.src == SRC_IMMEDIATE
      |=> acc == ($past(acc) & $past(req.immediate)) && instr_len == 2'h2;
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

  property p_direct_keep_acc;
    @(posedge clock) disable iff (!rst_b)
    accept && req.to_direct && req.src != SRC_IMMEDIATE
      |=> direct_wr.valid && $stable(acc);
  endproperty
  a_direct_keep_acc: assert property (p_direct_keep_acc) else $error("direct wb wrong");

  property p_two_cycle;
    @(posedge clock) disable iff (!rst_b)
    accept && two_cycle |=> !done ##1 done && direct_wr.valid && instr_len == 2'h3;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two cycle timing wrong");

  property p_clear;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_CLEAR && !req.to_direct |=> acc == 8'h00 && !parity;
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");

  property p_rlc;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_ROT_LC && !req.to_direct
      |=> carry == $past(acc[7]) && acc[0] == $past(carry);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left carry wrong");

  property p_rrc;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_ROT_RC && !req.to_direct
      |=> carry == $past(acc[0]) && acc[7] == $past(carry);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right carry wrong");

  property p_swap;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_SWAP && !req.to_direct
      |=> acc == {$past(acc[3:0]), $past(acc[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_carry_kept;
    @(posedge clock) disable iff (!rst_b)
    !(accept && req.op inside {OP_ROT_LC, OP_ROT_RC} && !req.to_direct) |=> $stable(carry);
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry changed");

  property p_and_ind;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_AND && !req.to_direct && req.src == SRC_INDIRECT
      |=> acc == ($past(acc) & $past(req.operand)) && instr_len == 2'h1;
  endproperty
  a_and_ind: assert property (p_and_ind) else $error("and indirect wrong");

  property p_and_wb;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_AND && req.to_direct && req.src != SRC_IMMEDIATE
      |=> direct_wr.data == ($past(req.operand) & $past(acc)) && instr_len == 2'h2;
  endproperty
  a_and_wb: assert property (p_and_wb) else $error("and write-back wrong");

  property p_and_imm_wb;
    @(posedge clock) disable iff (!rst_b)
    accept && two_cycle && req.op == OP_AND
      |-> ##2 direct_wr.data == ($past(req.operand, 2) & $past(req.immediate, 2));
  endproperty
  a_and_imm_wb: assert property (p_and_imm_wb) else $error("and immediate wb wrong");

  property p_or_bank;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_OR && !req.to_direct && req.src == SRC_BANK
      |=> acc == ($past(acc) | $past(req.operand)) && instr_len == 2'h1;
  endproperty
  a_or_bank: assert property (p_or_bank) else $error("or register wrong");

  property p_or_ind;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_OR && !req.to_direct && req.src == SRC_INDIRECT
      |=> acc == ($past(acc) | $past(req.operand)) && done;
  endproperty
  a_or_ind: assert property (p_or_ind) else $error("or indirect wrong");

  property p_or_wb;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_OR && req.to_direct && req.src != SRC_IMMEDIATE
      |=> direct_wr.data == ($past(req.operand) | $past(acc)) && instr_len == 2'h2;
  endproperty
  a_or_wb: assert property (p_or_wb) else $error("or write-back wrong");

  property p_or_imm_wb;
    @(posedge clock) disable iff (!rst_b)
    accept && two_cycle && req.op == OP_OR
      |-> ##2 direct_wr.data == ($past(req.operand, 2) | $past(req.immediate, 2));
  endproperty
  a_or_imm_wb: assert property (p_or_imm_wb) else $error("or immediate wb wrong");

  property p_xor_bank;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_XOR && !req.to_direct && req.src == SRC_BANK
      |=> acc == ($past(acc) ^ $past(req.operand)) && instr_len == 2'h1;
  endproperty
  a_xor_bank: assert property (p_xor_bank) else $error("xor register wrong");

  property p_xor_dir;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_XOR && !req.to_direct && req.src == SRC_DIRECT
      |=> acc == ($past(acc) ^ $past(req.operand)) && instr_len == 2'h2;
  endproperty
  a_xor_dir: assert property (p_xor_dir) else $error("xor direct wrong");

  property p_xor_ind;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_XOR && !req.to_direct && req.src == SRC_INDIRECT
      |=> acc == ($past(acc) ^ $past(req.operand)) && instr_len == 2'h1;
  endproperty
  a_xor_ind: assert property (p_xor_ind) else $error("xor indirect wrong");

  property p_xor_imm;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_XOR && !req.to_direct && req.src == SRC_IMMEDIATE
      |=> acc == ($past(acc) ^ $past(req.immediate)) && instr_len == 2'h2;
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

  property p_compl;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_COMPL && !req.to_direct
      |=> acc == ~$past(acc) && instr_len == 2'h1;
  endproperty
  a_compl: assert property (p_compl) else $error("complement wrong");

  property p_rot_l;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_ROT_L && !req.to_direct
      |=> acc == {$past(acc[6:0]), $past(acc[7])};
  endproperty
  a_rot_l: assert property (p_rot_l) else $error("rotate left wrong");

  property p_rot_r;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_ROT_R && !req.to_direct
      |=> acc == {$past(acc[0]), $past(acc[7:1])};
  endproperty
  a_rot_r: assert property (p_rot_r) else $error("rotate right wrong");

  property p_move;
    @(posedge clock) disable iff (!rst_b)
    accept && req.op == OP_MOVE && !req.to_direct
      |=> acc == $past(req.operand) && instr_len == 2'h1;
  endproperty
  a_move: assert property (p_move) else $error("register move wrong");

endmodule : accumulator_logic_ops
`default_nettype wire

// ==== dv/tb_accumulator_logic_ops.sv ====
// testbench: self-checking scenarios for the accumulator logical datapath
`timescale 1ns/1ps
`default_nettype none
module tb_accumulator_logic_ops;
  import logic_ops_pkg::*;
  // ----------------------------------------
  // clock, stimulus and observed signals
  // ----------------------------------------
  logic clock;
  logic rst_b;
  logic req_valid;
  logic_req_t req;
  logic req_ready;
  logic done;
  logic [7:0] acc;
  logic carry;
  logic parity;
  direct_wr_t direct_wr;
  logic [1:0] instr_len;
  int errors;
  int checks_done;
  int cycles;
  logic [7:0] exp_acc;
  logic exp_c;

  accumulator_logic_ops dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .acc(acc), .carry(carry), .parity(parity),
    .direct_wr(direct_wr), .instr_len(instr_len));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude;
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // a hang must still reach the report, so the ceiling counts as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // own reference, kept apart from the design's unit
  function automatic logic [8:0] model(op_t op, logic [7:0] a, logic [7:0] b, logic c);
    case (op)
      OP_AND: return {c, a & b};
      OP_OR: return {c, a | b};
      OP_XOR: return {c, a ^ b};
      OP_CLEAR: return {c, 8'h00};
      OP_COMPL: return {c, ~a};
      OP_ROT_L: return {c, a[6:0], a[7]};
      OP_ROT_LC: return {a[7], a[6:0], c};
      OP_ROT_R: return {c, a[0], a[7:1]};
      OP_ROT_RC: return {a[0], c, a[7:1]};
      OP_SWAP: return {c, a[3:0], a[7:4]};
      default: return {c, b};
    endcase
  endfunction : model

  task automatic do_op(input op_t op, input src_t src, input logic td, input logic [7:0] o,
      input logic [7:0] im);
    logic [8:0] r;
    logic [1:0] len;
    logic two;
    two = td && src == SRC_IMMEDIATE;
    r = model(op, td ? o : exp_acc, (src == SRC_IMMEDIATE) ? im : (td ? exp_acc : o), exp_c);
    len = (op >= OP_CLEAR) ? LEN_ONE : two ? LEN_THREE :
      (src == SRC_DIRECT || src == SRC_IMMEDIATE) ? LEN_TWO : LEN_ONE;
    @(negedge clock);
    req_valid = 1'b1;
    req = '{op: op, src: src, to_direct: td, operand: o, immediate: im};
    @(posedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    if (two) begin
      chk("ready_mid", 9'h000, 9'(req_ready));
      chk("done_mid", 9'h000, 9'(done));
      @(negedge clock);
    end
    if (!td) exp_acc = r[7:0];
    exp_c = r[8];
    chk("done", 9'h001, 9'(done));
    chk("acc", 9'(exp_acc), 9'(acc));
    chk("carry", 9'(exp_c), 9'(carry));
    chk("parity", 9'(^exp_acc), 9'(parity));
    chk("len", 9'(len), 9'(instr_len));
    chk("wr_valid", 9'(td), 9'(direct_wr.valid));
    if (td) chk("wr_data", 9'(r[7:0]), 9'(direct_wr.data));
    @(negedge clock);
    chk("done_low", 9'h000, 9'(done));
    chk("wr_low", 9'h000, 9'(direct_wr.valid));
  endtask : do_op

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    @(negedge clock);
    rst_b = 1'b0;
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    exp_acc = ACC_RESET;
    exp_c = CARRY_RESET;
    chk("rst_acc", 9'(ACC_RESET), 9'(acc));
    chk("rst_carry", 9'(CARRY_RESET), 9'(carry));
    chk("rst_parity", 9'h000, 9'(parity));
    chk("rst_ready", 9'h001, 9'(req_ready));
    chk("rst_done", 9'h000, 9'(done));
    chk("rst_len", 9'(LEN_ONE), 9'(instr_len));
  endtask : t_reset

  task automatic t_and;
    do_op(OP_MOVE, SRC_BANK, 1'b0, 8'hF5, 8'h00);
    do_op(OP_AND, SRC_DIRECT, 1'b0, 8'h3C, 8'h00);
    do_op(OP_AND, SRC_INDIRECT, 1'b0, 8'h1F, 8'h00);
    do_op(OP_AND, SRC_IMMEDIATE, 1'b0, 8'h00, 8'h17);
    do_op(OP_AND, SRC_DIRECT, 1'b1, 8'hFF, 8'h00);
    do_op(OP_AND, SRC_IMMEDIATE, 1'b1, 8'hCA, 8'h6F);
  endtask : t_and

  task automatic t_or;
    do_op(OP_OR, SRC_BANK, 1'b0, 8'h40, 8'h00);
    do_op(OP_OR, SRC_INDIRECT, 1'b0, 8'h08, 8'h00);
    do_op(OP_OR, SRC_DIRECT, 1'b1, 8'h21, 8'h00);
    do_op(OP_OR, SRC_IMMEDIATE, 1'b1, 8'h90, 8'h03);
  endtask : t_or

  task automatic t_xor;
    do_op(OP_XOR, SRC_BANK, 1'b0, 8'hFF, 8'h00);
    do_op(OP_XOR, SRC_DIRECT, 1'b0, 8'h5A, 8'h00);
    do_op(OP_XOR, SRC_INDIRECT, 1'b0, 8'h81, 8'h00);
    do_op(OP_XOR, SRC_IMMEDIATE, 1'b0, 8'h00, 8'h3E);
  endtask : t_xor

  // carry and the moving bit differ at each rotate through carry, so a swapped path shows
  task automatic t_unary;
    do_op(OP_MOVE, SRC_BANK, 1'b0, 8'h81, 8'h00);
    do_op(OP_ROT_L, SRC_BANK, 1'b0, 8'h00, 8'h00);
    do_op(OP_ROT_R, SRC_BANK, 1'b0, 8'h00, 8'h00);
    do_op(OP_ROT_RC, SRC_BANK, 1'b0, 8'h00, 8'h00);
    do_op(OP_ROT_LC, SRC_BANK, 1'b0, 8'h00, 8'h00);
    do_op(OP_COMPL, SRC_BANK, 1'b0, 8'h00, 8'h00);
    do_op(OP_SWAP, SRC_BANK, 1'b0, 8'h00, 8'h00);
    do_op(OP_ROT_LC, SRC_BANK, 1'b0, 8'h00, 8'h00);
    do_op(OP_CLEAR, SRC_BANK, 1'b0, 8'h00, 8'h00);
  endtask : t_unary

  task automatic t_back2back;
    @(negedge clock);
    req_valid = 1'b1;
    req = '{op: OP_MOVE, src: SRC_BANK, to_direct: 1'b0, operand: 8'h5A, immediate: 8'h00};
    @(posedge clock);
    @(negedge clock);
    chk("b2b_acc1", 9'h05A, 9'(acc));
    chk("b2b_ready", 9'h001, 9'(req_ready));
    req = '{op: OP_COMPL, src: SRC_BANK, to_direct: 1'b0, operand: 8'h00, immediate: 8'h00};
    @(posedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    chk("b2b_done", 9'h001, 9'(done));
    chk("b2b_acc2", 9'h0A5, 9'(acc));
    exp_acc = 8'hA5;
  endtask : t_back2back

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    t_reset();
    t_and();
    t_or();
    t_xor();
    t_unary();
    t_back2back();
    t_reset();
    conclude();
  end
endmodule : tb_accumulator_logic_ops
`default_nettype wire
